// [verilog/teleprot_link_defs.svh]
`ifndef TELEPROT_LINK_DEFS_SVH
`define TELEPROT_LINK_DEFS_SVH

// ----------------------------------------------------------------
// Line format
// ----------------------------------------------------------------
`define RATE_MULT 1
`define CHAN_KBPS 64
`define FRAME_BITS 256
`define FRAME_RATE_HZ 8000
`define SLOT_BITS 8
`define LINE_BPS (`FRAME_BITS * `FRAME_RATE_HZ)
`define PAYLOAD_SLOT 5'h01
`define TS0_FAS 8'h9B
`define TS0_NFAS 8'hDF
`define FAS_MASK 7'h1B
`define IDLE_WORD 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_HZ 20000000
`define NCO_MOD (`MCLK_HZ / 1000)
`define NCO_INC (`LINE_BPS / 1000)

`endif

// [verilog/teleprot_link_pkg.sv]
package teleprot_link_pkg;
    typedef enum logic [0:0] {
        TIMING_INTERNAL = 1'b0,
        TIMING_LOOPED = 1'b1
    } timing_mode_t;

    typedef enum logic [0:0] {
        RX_HUNT = 1'b0,
        RX_LOCKED = 1'b1
    } rx_state_t;
endpackage : teleprot_link_pkg

// [verilog/teleprot_link.sv]
`timescale 1ns/1ps
`include "teleprot_link_defs.svh"

// ----------------------------------------------------------------
// One channel: receive framer on the recovered clock, transmit framer on mclk
// ----------------------------------------------------------------
module link_channel (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rclk,
    input wire logic rx_line,
    input wire logic mode_pin,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic tx_line,
    output logic tx_bit_strobe,
    output teleprot_link_pkg::timing_mode_t mode_active,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_locked
);
    import teleprot_link_pkg::*;

    localparam logic [15:0] NCO_MOD = 16'(`NCO_MOD);
    localparam logic [15:0] NCO_INC = 16'(`NCO_INC);

    // ------------------------------------------------------------
    // Receive side, recovered clock domain
    // ------------------------------------------------------------
    rx_state_t rx_state;
    logic [7:0] rx_shift;
    logic [7:0] rx_cnt;
    logic rx_odd;
    logic [7:0] rx_hold;
    logic rx_word_tgl;
    logic rx_bit_tgl;
    logic [7:0] next_rx_shift;

    assign next_rx_shift = {rx_shift[6:0], rx_line};

    always_ff @(posedge rclk or posedge rst) begin
        if (rst) begin
            rx_bit_tgl <= 1'b0;
        end else begin
            rx_bit_tgl <= ~rx_bit_tgl; // see RQ5
        end
    end

    always_ff @(posedge rclk or posedge rst) begin
        if (rst) begin
            rx_state <= RX_HUNT;
            rx_shift <= 8'h00;
            rx_cnt <= 8'h00;
            rx_odd <= 1'b0;
            rx_hold <= 8'h00;
            rx_word_tgl <= 1'b0;
        end else begin
            rx_shift <= next_rx_shift;
            rx_cnt <= rx_cnt + 8'h01;
            case (rx_state)
                RX_HUNT: begin
                    // Alignment word just completed: we now sit at bit 7 of slot 0
                    if (next_rx_shift[6:0] == `FAS_MASK) begin // see RQ3
                        rx_state <= RX_LOCKED;
                        rx_cnt <= 8'h08;
                        rx_odd <= 1'b0;
                    end
                end
                RX_LOCKED: begin
                    if (rx_cnt == 8'h07 && !rx_odd && next_rx_shift[6:0] != `FAS_MASK) begin
                        rx_state <= RX_HUNT; // see RQ3
                    end
                    if (rx_cnt == 8'hFF) begin
                        rx_odd <= ~rx_odd; // see RQ2
                    end
                    if (rx_cnt == {`PAYLOAD_SLOT, 3'h7}) begin
                        rx_hold <= next_rx_shift; // see RQ1
                        rx_word_tgl <= ~rx_word_tgl;
                    end
                end
                default: rx_state <= RX_HUNT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Crossings into mclk
    // ------------------------------------------------------------
    // rx_hold stands for a whole frame, far longer than the toggle sync delay
    logic [2:0] bit_sync;
    logic [2:0] word_sync;
    logic [1:0] lock_sync;
    logic rx_edge;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bit_sync <= 3'h0;
            word_sync <= 3'h0;
            lock_sync <= 2'h0;
        end else begin
            bit_sync <= {bit_sync[1:0], rx_bit_tgl};
            word_sync <= {word_sync[1:0], rx_word_tgl};
            lock_sync <= {lock_sync[0], rx_state == RX_LOCKED};
        end
    end

    assign rx_edge = bit_sync[2] ^ bit_sync[1];
    assign rx_locked = lock_sync[1];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= word_sync[2] ^ word_sync[1];
            if (word_sync[2] ^ word_sync[1]) begin
                rx_data <= rx_hold;
            end
        end
    end

    // ------------------------------------------------------------
    // Timing mode strap, taken once after reset
    // ------------------------------------------------------------
    logic [1:0] mode_sync;
    logic mode_taken;

    // No reset here: the strap must already be through both stages when reset lets go
    always_ff @(posedge mclk) begin
        mode_sync <= {mode_sync[0], mode_pin};
    end

    // Switching source mid-stream would tear frames, so the strap is frozen
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_taken <= 1'b0;
            mode_active <= TIMING_INTERNAL;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1; // see RQ9
            mode_active <= timing_mode_t'(mode_sync[1]); // see RQ8
        end
    end

    // ------------------------------------------------------------
    // Internal bit clock: fractional divider to the line rate
    // ------------------------------------------------------------
    logic [15:0] nco_acc;
    logic [15:0] next_nco;
    logic nco_tick;
    logic bit_strobe;

    assign next_nco = nco_acc + NCO_INC;
    assign nco_tick = (next_nco >= NCO_MOD);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nco_acc <= 16'h0000;
        end else if (nco_tick) begin
            nco_acc <= next_nco - NCO_MOD; // see RQ4
        end else begin
            nco_acc <= next_nco;
        end
    end

    // Source held back until the strap has been taken
    assign bit_strobe = mode_taken &&
        ((mode_active == TIMING_LOOPED) ? rx_edge : nco_tick); // see RQ4 see RQ5

    // ------------------------------------------------------------
    // Transmit framer
    // ------------------------------------------------------------
    logic [7:0] tx_cnt;
    logic tx_odd;
    logic [7:0] tx_shift;
    logic [7:0] tx_hold;
    logic tx_full;
    logic load;
    logic [7:0] next_word;

    assign tx_ready = !tx_full;
    assign load = bit_strobe && (tx_cnt[2:0] == 3'h0);

    always_comb begin
        next_word = `IDLE_WORD;
        if (tx_cnt[7:3] == 5'h00) begin
            next_word = tx_odd ? `TS0_NFAS : `TS0_FAS; // see RQ3
        end else if (tx_cnt[7:3] == `PAYLOAD_SLOT && tx_full) begin
            next_word = tx_hold; // see RQ1
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_full <= 1'b0;
            tx_hold <= 8'h00;
        end else if (tx_valid && !tx_full) begin
            tx_full <= 1'b1;
            tx_hold <= tx_data;
        end else if (load && tx_cnt[7:3] == `PAYLOAD_SLOT) begin
            tx_full <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_cnt <= 8'h00;
            tx_odd <= 1'b0;
            tx_shift <= 8'h00;
            tx_line <= 1'b1;
            tx_bit_strobe <= 1'b0;
        end else begin
            tx_bit_strobe <= bit_strobe;
            if (bit_strobe) begin
                tx_cnt <= tx_cnt + 8'h01; // see RQ2
                if (tx_cnt == 8'hFF) begin
                    tx_odd <= ~tx_odd;
                end
                if (load) begin
                    tx_line <= next_word[7];
                    tx_shift <= {next_word[6:0], 1'b0};
                end else begin
                    tx_line <= tx_shift[7];
                    tx_shift <= {tx_shift[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_frame_end;
        bit_strobe && tx_cnt == 8'hFF;
    endsequence

    sequence s_slot_start(logic [4:0] slot);
        load && tx_cnt[7:3] == slot;
    endsequence

    a_frame_wrap: assert property (@(posedge mclk) disable iff (rst) // see RQ2
        s_frame_end |=> tx_cnt == 8'h00 && tx_odd != $past(tx_odd))
        else $error("frame did not wrap after 256 bits");

    a_fas_word: assert property (@(posedge mclk) disable iff (rst) // see RQ3
        s_slot_start(5'h00) ##0 !tx_odd |=> tx_line == 1'b1 && tx_shift == 8'h36)
        else $error("alignment word not sent in even frame");

    a_nfas_word: assert property (@(posedge mclk) disable iff (rst) // see RQ3
        s_slot_start(5'h00) ##0 tx_odd |=> tx_line == 1'b1 && tx_shift == 8'hBE)
        else $error("non-alignment word wrong in odd frame");

    a_idle_slots: assert property (@(posedge mclk) disable iff (rst) // see RQ1
        load && tx_cnt[7:3] > `PAYLOAD_SLOT |=> tx_line && tx_shift == 8'hFE)
        else $error("slot outside payload not idle");

    a_internal_pace: assert property (@(posedge mclk) disable iff (rst) // see RQ4
        bit_strobe && mode_active == TIMING_INTERNAL |=> !bit_strobe [*8])
        else $error("internal bit clock faster than line rate");

    a_internal_source: assert property (@(posedge mclk) disable iff (rst) // see RQ4
        bit_strobe && mode_active == TIMING_INTERNAL |=> ##[8:9] bit_strobe)
        else $error("internal bit clock slower than line rate");

    a_looped_source: assert property (@(posedge mclk) disable iff (rst) // see RQ5
        bit_strobe && mode_active == TIMING_LOOPED |-> rx_edge)
        else $error("looped mode strobe not from recovered clock");

    a_mode_static: assert property (@(posedge mclk) disable iff (rst) // see RQ9
        mode_taken |=> $stable(mode_active) && mode_taken)
        else $error("timing mode changed after capture");

    a_payload_taken: assert property (@(posedge mclk) disable iff (rst) // see RQ1
        s_slot_start(`PAYLOAD_SLOT) ##0 tx_full |=> !tx_full && tx_shift == {tx_hold[6:0], 1'b0})
        else $error("payload word not consumed in its slot");
endmodule : link_channel

// ----------------------------------------------------------------
// Top: two independent channels
// ----------------------------------------------------------------
// Notes on behaviour
// RQ1 - User data runs at one 64 kbps slot per frame only, no rate multiple above one.
// RQ2 - Frames are 256 bits long and follow each other back to back at 8000 Hz.
// RQ3 - Each frame carries the standard alignment pattern so a multiplexer can lock on; the code sends it in even frames only.
// RQ4 - In internal timing the transmit bit clock comes from the device's own source.
// RQ5 - In looped timing the transmit bit clock follows the recovered receive clock.
// RQ6 - On a direct link one end runs internal and the other looped timing.
// RQ7 - A channel facing a multiplexer should run looped from that system's clock.
// RQ8 - Each of the two channels picks its timing mode on its own.
// RQ9 - The timing mode strap is read once after reset and never changes while sending.
module teleprot_link (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] rclk,
    input wire logic [1:0] rx_line,
    input wire logic [1:0] mode_pin,
    input wire logic [15:0] tx_data,
    input wire logic [1:0] tx_valid,
    output logic [1:0] tx_ready,
    output logic [1:0] tx_line,
    output logic [1:0] tx_bit_strobe,
    output logic [1:0] mode_looped,
    output logic [15:0] rx_data,
    output logic [1:0] rx_valid,
    output logic [1:0] rx_locked
);
    import teleprot_link_pkg::*;

    timing_mode_t mode_active [2];

    // Separate straps per channel; RQ6 and RQ7 are met by how they are set
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        link_channel u_chan (
            .mclk(mclk),
            .rst(rst),
            .rclk(rclk[ch]),
            .rx_line(rx_line[ch]),
            .mode_pin(mode_pin[ch]), // see RQ6 see RQ7 see RQ8
            .tx_data(tx_data[ch*8 +: 8]),
            .tx_valid(tx_valid[ch]),
            .tx_ready(tx_ready[ch]),
            .tx_line(tx_line[ch]),
            .tx_bit_strobe(tx_bit_strobe[ch]),
            .mode_active(mode_active[ch]),
            .rx_data(rx_data[ch*8 +: 8]),
            .rx_valid(rx_valid[ch]),
            .rx_locked(rx_locked[ch])
        );
        assign mode_looped[ch] = (mode_active[ch] == TIMING_LOOPED);
    end
endmodule : teleprot_link

// [testbench/link_far_end.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Far end: framed line with its own bit clock
// ----------------------------------------------------------------
module link_far_end #(
    parameter int HALF = 40,
    parameter int LEAD = 64
) (
    output logic rclk,
    output logic rx_line,
    input wire logic [7:0] word,
    output logic sync
);
    int pos = 0;
    int bitn;
    logic [7:0] cur = 8'hFF;
    logic [7:0] slot;

    initial begin
        rclk = 1'b0;
        rx_line = 1'b1;
        sync = 1'b0;
    end

    always #(HALF) rclk = ~rclk;

    // Data moves on the falling edge so it is steady around the sampling edge
    always @(negedge rclk) begin
        if (pos >= LEAD) begin
            bitn = (pos - LEAD) % 256;
            if (bitn == 0) begin
                cur = word;
            end
            slot = (bitn < 8) ? (((pos - LEAD) / 256) % 2 ? 8'hDF : 8'h9B) : 8'hFF;
            if (bitn >= 8 && bitn < 16) begin
                slot = cur;
            end
            sync <= (bitn == 0);
            rx_line <= slot[7 - bitn % 8];
        end
        pos++;
    end
endmodule : link_far_end

// [testbench/optical_teleprot_link_timing_test.sv]
`timescale 1ns/1ps

module optical_teleprot_link_timing_test;
    import teleprot_link_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    wire [1:0] rclk;
    wire [1:0] rx_line;
    wire [1:0] far_sync;
    logic [1:0] mode_pin = 2'b10;
    logic [15:0] tx_data = 16'h0000;
    logic [1:0] tx_valid = 2'b00;
    logic [1:0] tx_ready, tx_line, tx_bit_strobe, mode_looped, rx_valid, rx_locked;
    logic [15:0] rx_data;
    logic [7:0] far_word [2];
    logic [7:0] txq [2][$];
    logic [7:0] rxq [2][$];
    logic [7:0] shift [2];
    int strobes [2] = '{0, 0};
    int edges1 = 0;
    int cyc = 0;
    int frame_mark = 0;
    int num_errors = 0;
    int check_count = 0;

    always #25 mclk = ~mclk;

    teleprot_link i_dut (.mclk(mclk), .rst(rst), .rclk(rclk), .rx_line(rx_line),
        .mode_pin(mode_pin), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_line(tx_line), .tx_bit_strobe(tx_bit_strobe), .mode_looped(mode_looped),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_locked(rx_locked));

    // Channel 1 faces a clock-giving far end and runs looped; its bit clock is slow
    // enough for the synchroniser to see every edge
    link_far_end #(.HALF(40)) i_far0 (.rclk(rclk[0]), .rx_line(rx_line[0]),
        .word(far_word[0]), .sync(far_sync[0]));
    link_far_end #(.HALF(200)) i_far1 (.rclk(rclk[1]), .rx_line(rx_line[1]),
        .word(far_word[1]), .sync(far_sync[1]));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Payload offers, one per frame, with the slots expected on the line
    // ----------------------------------------------------------------
    task automatic feed(input int c);
        logic [7:0] b;
        for (int f = 0; f < 4; f++) begin
            b = 8'($urandom);
            @(negedge mclk);
            while (tx_ready[c] !== 1'b1) @(negedge mclk);
            txq[c].push_back(f % 2 ? 8'hDF : 8'h9B);
            txq[c].push_back(b);
            repeat (30) txq[c].push_back(8'hFF);
            @(posedge mclk);
            tx_valid[c] <= 1'b1;
            tx_data[8*c +: 8] <= b;
            @(posedge mclk);
            tx_valid[c] <= 1'b0;
        end
    endtask : feed

    always @(posedge far_sync[0]) begin
        rxq[0].push_back(far_word[0]);
        far_word[0] <= 8'($urandom);
    end

    always @(posedge far_sync[1]) begin
        rxq[1].push_back(far_word[1]);
        far_word[1] <= 8'($urandom);
    end

    always @(posedge rclk[1]) begin
        if (!rst) begin
            edges1++;
        end
    end

    // ----------------------------------------------------------------
    // Output watcher
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        for (int c = 0; c < 2; c++) begin
            if (tx_bit_strobe[c] === 1'b1) begin
                shift[c] = {shift[c][6:0], tx_line[c]};
                strobes[c]++;
                if (strobes[c] % 8 == 0 && txq[c].size() > 0) begin
                    check({24'd0, shift[c]}, {24'd0, txq[c].pop_front()});
                end
            end
            if (rx_valid[c] === 1'b1 && rxq[c].size() > 0) begin
                check({24'd0, rx_data[8*c +: 8]}, {24'd0, rxq[c].pop_front()});
            end
        end
        // Internal timing gives 256 bits in exactly 2500 mclk, give or take one tick
        if (tx_bit_strobe[0] === 1'b1 && strobes[0] % 256 == 1) begin
            if (strobes[0] > 1) begin
                check({31'd0, (cyc - frame_mark) inside {[2499:2501]}}, 32'd1);
            end
            frame_mark = cyc;
        end
    end

    initial begin
        void'($urandom(43040));
        far_word[0] = 8'($urandom);
        far_word[1] = 8'($urandom);
        repeat (8) @(posedge mclk);
        check({26'd0, tx_line, tx_ready, mode_looped}, 32'h0000_003C);
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        check({30'd0, mode_looped}, 32'h0000_0002);
        mode_pin <= 2'b01;
        fork
            feed(0);
            feed(1);
        join
        repeat (5500) @(posedge mclk);
        check({30'd0, mode_looped}, 32'h0000_0002);
        check({30'd0, rx_locked}, 32'h0000_0003);
        check(32'(txq[0].size() + txq[1].size()), 32'd0);
        check({31'd0, rxq[0].size() <= 1 && rxq[1].size() <= 1}, 32'd1);
        check({31'd0, (edges1 - strobes[1]) inside {[-4:4]}}, 32'd1);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        close_out();
    end
endmodule : optical_teleprot_link_timing_test
